/* File: common/wwd_defs.svh */
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

`define WWD_CLK_NS 20
`define WWD_VIN_REACT_NS 3000
`define WWD_VIN_REACT_CYC ((`WWD_VIN_REACT_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`define WWD_NORM_TICK_NS 100000
`define WWD_NORM_TICK_CYC (`WWD_NORM_TICK_NS / `WWD_CLK_NS)
`define WWD_SLOW_TICK_NS 1000000
`define WWD_SLOW_TICK_CYC (`WWD_SLOW_TICK_NS / `WWD_CLK_NS)
`define WWD_CW_US 80000
`define WWD_OW_US 40000
`define WWD_WDR_US 2500
`define WWD_WD_US 100000
`define WWD_CW_TICKS (`WWD_CW_US * 1000 / `WWD_NORM_TICK_NS)
`define WWD_OW_TICKS (`WWD_OW_US * 1000 / `WWD_NORM_TICK_NS)
`define WWD_WDR_TICKS (`WWD_WDR_US * 1000 / `WWD_NORM_TICK_NS)
`define WWD_POR_TICKS (`WWD_WD_US * 1000 / `WWD_NORM_TICK_NS)
`define WWD_POR_QTR_TICKS (`WWD_POR_TICKS / 4)
`define WWD_SLEEP_PULSE_US 3000
`define WWD_SLEEP_PERIOD_US 1000000
`define WWD_SLEEP_PULSE_TICKS (`WWD_SLEEP_PULSE_US * 1000 / `WWD_SLOW_TICK_NS)
`define WWD_SLEEP_PERIOD_TICKS (`WWD_SLEEP_PERIOD_US * 1000 / `WWD_SLOW_TICK_NS)
`define WWD_SERVICES_FOR_EN 3
`define WWD_MISSES_FOR_SLEEP 3

`endif

/* File: common/wwd_pkg.sv */
package wwd_pkg;
	typedef enum logic [2:0] {
		WWD_ST_POR,
		WWD_ST_CLOSED,
		WWD_ST_OPEN,
		WWD_ST_WDR,
		WWD_ST_SLEEP_HI,
		WWD_ST_SLEEP_LO
	} wwd_state_t;
endpackage

/* File: common/wwd_tick_if.sv */
`timescale 1ns/100ps
interface wwd_tick_if;
	logic slow;
	logic restart;
	logic tick;
	modport gen (
		input slow,
		input restart,
		output tick
	);
	modport user (
		output slow,
		output restart,
		input tick
	);
endinterface

/* File: dv/wwd_mcu.sv */
`timescale 1ns/100ps
// Processor stand-in: while go_i is high it pulls the trigger low for three cycles
// every gap_i+1 cycles; otherwise the line idles high as its pull-up holds it.
module wwd_mcu (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] gap_i,
	output logic trig_n_o
);
	logic [15:0] cnt_reg;
	always_ff @(posedge clk_i) begin
		if (!go_i || cnt_reg == gap_i) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	assign trig_n_o = !(go_i && cnt_reg >= gap_i - 16'h0002);
endmodule

/* File: dv/wwd_top_sva.sv */
`timescale 1ns/100ps
module wwd_top_sva #(
	parameter bit SLEEP_VARIANT = 1'b1,
	parameter int NORM_TICK_CYC = 10,
	parameter int SLOW_TICK_CYC = 20,
	parameter int CW_TICKS = 8,
	parameter int OW_TICKS = 4,
	parameter int WDR_TICKS = 2,
	parameter int POR_TICKS = 10,
	parameter int POR_QTR_TICKS = 3,
	parameter int SLEEP_PULSE_TICKS = 2,
	parameter int VIN_REACT_CYC = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic watchdog_trigger_n_i,
	input wire logic monitored_voltage_low_i,
	input wire logic reset_out_n_o,
	input wire logic reset_out_oe_b_o,
	input wire logic enable_n_o,
	input wire logic sleep_o
);
	localparam int CW = CW_TICKS * NORM_TICK_CYC;
	localparam int WIN = (CW_TICKS + OW_TICKS) * NORM_TICK_CYC;
	localparam int WDR = WDR_TICKS * NORM_TICK_CYC;
	localparam int WDR_HI = WDR + 4;
	localparam int SLP = SLEEP_PULSE_TICKS * SLOW_TICK_CYC;
	localparam int SLP_HI = SLP + 4;
	localparam int POR = (SLEEP_VARIANT ? POR_TICKS : POR_QTR_TICKS) * NORM_TICK_CYC;
	logic [31:0] low_cnt;
	logic [31:0] hi_age;
	logic [31:0] trig_age;
	logic [31:0] por_age;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Ages in cycles: flag held low-voltage, reset released, trigger idle, since supply good.
	always_ff @(posedge clk_i) begin
		low_cnt <= (!rst_b_i || !monitored_voltage_low_i) ? 32'h0 : low_cnt + 32'h1;
		hi_age <= (!rst_b_i || !reset_out_n_o) ? 32'h0 : hi_age + 32'h1;
		trig_age <= (!rst_b_i || !watchdog_trigger_n_i) ? 32'h0 : trig_age + 32'h1;
		por_age <= (!rst_b_i || low_cnt >= VIN_REACT_CYC) ? 32'h0 : por_age + 32'h1;
	end
	sequence s_wdr_end;
		##[WDR:WDR_HI] $rose(reset_out_n_o);
	endsequence
	sequence s_slp_end;
		##[SLP:SLP_HI] $rose(reset_out_n_o);
	endsequence
	sequence s_early_fall;
		$fell(watchdog_trigger_n_i) && reset_out_n_o && !sleep_o && !monitored_voltage_low_i
			&& hi_age > 4 && hi_age < CW - 8;
	endsequence
	property p_res_en;
		(reset_out_oe_b_o == reset_out_n_o) && (reset_out_n_o || enable_n_o);
	endproperty
	a_res_en: assert property (p_res_en) else $error("enable active during reset");
	property p_lowv;
		low_cnt == VIN_REACT_CYC |-> ##[0:3] (!reset_out_n_o && enable_n_o);
	endproperty
	a_lowv: assert property (p_lowv) else $error("low voltage did not force reset");
	property p_por;
		$rose(reset_out_n_o) |-> por_age >= POR - 2;
	endproperty
	a_por: assert property (p_por) else $error("reset released before delay");
	property p_por_rel;
		por_age == POR + 8 && !monitored_voltage_low_i |-> reset_out_n_o;
	endproperty
	a_por_rel: assert property (p_por_rel) else $error("reset held past delay");
	property p_wdr;
		$fell(reset_out_n_o) && !sleep_o && !monitored_voltage_low_i |-> s_wdr_end;
	endproperty
	a_wdr: assert property (p_wdr) else $error("watchdog reset width wrong");
	property p_slp;
		$fell(reset_out_n_o) && sleep_o |-> s_slp_end;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep reset width wrong");
	property p_miss;
		$fell(reset_out_n_o) && !sleep_o && !monitored_voltage_low_i && trig_age > hi_age
			|-> hi_age >= WIN && hi_age <= WIN + 6;
	endproperty
	a_miss: assert property (p_miss) else $error("missed window timing wrong");
	property p_closed;
		s_early_fall |-> ##[2:6] $fell(reset_out_n_o);
	endproperty
	a_closed: assert property (p_closed) else $error("early trigger not punished");
	property p_en;
		$fell(enable_n_o) |-> reset_out_n_o && hi_age >= 3 * CW;
	endproperty
	a_en: assert property (p_en) else $error("enable before three services");
	property p_sleep_out;
		sleep_o && $changed(watchdog_trigger_n_i) |-> ##[2:6] !sleep_o;
	endproperty
	a_sleep_out: assert property (p_sleep_out) else $error("sleep not left on edge");
endmodule
bind wwd_top wwd_top_sva #(.SLEEP_VARIANT(SLEEP_VARIANT), .NORM_TICK_CYC(NORM_TICK_CYC),
	.SLOW_TICK_CYC(SLOW_TICK_CYC), .CW_TICKS(CW_TICKS), .OW_TICKS(OW_TICKS),
	.WDR_TICKS(WDR_TICKS), .POR_TICKS(POR_TICKS), .POR_QTR_TICKS(POR_QTR_TICKS),
	.SLEEP_PULSE_TICKS(SLEEP_PULSE_TICKS), .VIN_REACT_CYC(VIN_REACT_CYC)) u_sva (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .watchdog_trigger_n_i(watchdog_trigger_n_i),
	.monitored_voltage_low_i(monitored_voltage_low_i), .reset_out_n_o(reset_out_n_o),
	.reset_out_oe_b_o(reset_out_oe_b_o), .enable_n_o(enable_n_o), .sleep_o(sleep_o));

/* File: dv/wwd_top_test.sv */
`timescale 1ns/100ps
`include "wwd_defs.svh"
module wwd_top_test;
	// Only the tick lengths and the low-voltage reaction time are shortened; every interval keeps its nominal tick count.
	localparam int NT = 2;
	localparam int ST = 4;
	localparam int POR = `WWD_POR_TICKS * NT;
	localparam int WIN = (`WWD_CW_TICKS + `WWD_OW_TICKS) * NT;
	localparam int WDR = `WWD_WDR_TICKS * NT;
	localparam int SLP = `WWD_SLEEP_PULSE_TICKS * ST;
	localparam int SHI = (`WWD_SLEEP_PERIOD_TICKS - `WWD_SLEEP_PULSE_TICKS) * ST;
	localparam int SVC = 1998;
	logic clk, rst_b, vlow, go, trig_n, res_n, oe_b, en_n, slp;
	logic [15:0] gap;
	logic [2:0] obs;
	int errors, checks_done, cycles, n, a, b;
	assign obs = {slp, en_n, res_n};
	wwd_top #(.NORM_TICK_CYC(NT), .SLOW_TICK_CYC(ST), .VIN_REACT_CYC(4)) u_dut (
		.clk_i(clk), .rst_b_i(rst_b), .watchdog_trigger_n_i(trig_n),
		.monitored_voltage_low_i(vlow), .reset_out_n_o(res_n), .reset_out_oe_b_o(oe_b),
		.enable_n_o(en_n), .sleep_o(slp));
	wwd_mcu u_mcu (.clk_i(clk), .go_i(go), .gap_i(gap), .trig_n_o(trig_n));
	always #10 clk = ~clk;
	task automatic test_done();
		if (errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic cmp_range(input string what, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			errors++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask
	// Counts settled cycles until output w of {sleep, enable, reset} reaches lvl.
	task automatic wait_on(input int w, input logic lvl, output int k);
		k = 0;
		#1;
		while (obs[w] !== lvl && k < 9000) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	task automatic t_power_up();
		#1;
		cmp_bit("enable_n", 1'b1, en_n);
		wait_on(0, 1'b1, n);
		cmp_range("power-on delay", POR, POR + 5, n);
	endtask
	task automatic t_service();
		@(posedge clk);
		go <= 1'b1;
		gap <= 16'h07ce;
		wait_on(1, 1'b0, n);
		cmp_range("enable after services", 3 * SVC + 2, 3 * SVC + 6, n);
		cmp_bit("reset_out_n", 1'b1, res_n);
	endtask
	task automatic t_early();
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		go <= 1'b1;
		gap <= 16'h0027;
		wait_on(0, 1'b0, n);
		cmp_range("closed-window reset", 38, 48, n);
		cmp_bit("enable_n", 1'b1, en_n);
		wait_on(0, 1'b1, n);
		cmp_range("reset width", WDR - 1, WDR + 4, n);
		wait_on(0, 1'b0, n);
		cmp_range("second early reset", 24, 32, n);
		@(posedge clk);
		go <= 1'b0;
		wait_on(0, 1'b1, n);
	endtask
	task automatic t_lowv();
		@(posedge clk);
		vlow <= 1'b1;
		repeat (2) @(posedge clk);
		vlow <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		cmp_bit("reset after glitch", 1'b1, res_n);
		@(posedge clk);
		vlow <= 1'b1;
		go <= 1'b1;
		gap <= 16'h001d;
		wait_on(0, 1'b0, n);
		cmp_range("low voltage reset", 3, 9, n);
		cmp_bit("enable_n", 1'b1, en_n);
		repeat (20) @(posedge clk);
		vlow <= 1'b0;
		repeat (80) @(posedge clk);
		go <= 1'b0;
		wait_on(0, 1'b1, n);
		cmp_range("delay after low voltage", POR - 81, POR - 74, n);
	endtask
	task automatic t_miss_sleep();
		wait_on(0, 1'b0, n);
		cmp_range("first miss", WIN - 1, WIN + 6, n);
		for (int i = 0; i < 2; i++) begin
			wait_on(0, 1'b1, a);
			wait_on(0, 1'b0, b);
			cmp_range("repeat period", WIN + WDR, WIN + WDR + 8, a + b);
		end
		cmp_bit("enable_n", 1'b1, en_n);
		wait_on(2, 1'b1, n);
		cmp_range("sleep entry", WDR - 2, WDR + 4, n);
		wait_on(0, 1'b0, a);
		wait_on(0, 1'b1, b);
		cmp_range("sleep gap", SHI - 2, SHI + 8, a);
		cmp_range("sleep pulse", SLP, SLP + 4, b);
		@(posedge clk);
		go <= 1'b1;
		gap <= 16'h0009;
		wait_on(2, 1'b0, n);
		cmp_range("sleep exit", 8, 14, n);
		@(posedge clk);
		go <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		cmp_bit("reset after wake", 1'b1, res_n);
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		vlow = 1'b0;
		go = 1'b0;
		gap = 16'h0063;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_power_up();
		t_service();
		t_early();
		t_lowv();
		t_miss_sleep();
		test_done();
	end
endmodule

/* File: hdl/wwd_tick.sv */
`timescale 1ns/100ps
// Time base: one tick per NORM_CYC clocks, or per SLOW_CYC clocks in sleep.
module wwd_tick #(
	parameter int NORM_CYC = 5000,
	parameter int SLOW_CYC = 50000,
	parameter int PRE_W = 20
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	wwd_tick_if.gen tb
);
	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] last;
	logic tick_reg;

	assign last = tb.slow ? PRE_W'(SLOW_CYC - 1) : PRE_W'(NORM_CYC - 1);
	// A tick launched on the edge that enters a new interval is masked while restart stands.
	assign tb.tick = tick_reg && !tb.restart;

	// A restart realigns the prescaler so every interval starts on a full tick.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || tb.restart) begin
			pre_reg <= '0;
			tick_reg <= 1'b0;
		end else if (pre_reg >= last) begin
			pre_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			pre_reg <= pre_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end
endmodule

/* File: hdl/wwd_top.sv */
`timescale 1ns/100ps
`include "wwd_defs.svh"
// Windowed watchdog with power-on delay, enable output and sleep detector.
module wwd_top #(
	parameter bit SLEEP_VARIANT = 1'b1,
	parameter int NORM_TICK_CYC = `WWD_NORM_TICK_CYC,
	parameter int SLOW_TICK_CYC = `WWD_SLOW_TICK_CYC,
	parameter int CW_TICKS = `WWD_CW_TICKS,
	parameter int OW_TICKS = `WWD_OW_TICKS,
	parameter int WDR_TICKS = `WWD_WDR_TICKS,
	parameter int POR_TICKS = `WWD_POR_TICKS,
	parameter int POR_QTR_TICKS = `WWD_POR_QTR_TICKS,
	parameter int SLEEP_PULSE_TICKS = `WWD_SLEEP_PULSE_TICKS,
	parameter int SLEEP_PERIOD_TICKS = `WWD_SLEEP_PERIOD_TICKS,
	parameter int VIN_REACT_CYC = `WWD_VIN_REACT_CYC,
	parameter int TMR_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic watchdog_trigger_n_i,
	input wire logic monitored_voltage_low_i,
	output logic reset_out_n_o,
	output logic reset_out_oe_b_o,
	output logic enable_n_o,
	output logic sleep_o
);
	localparam logic [TMR_W-1:0] CW_LAST = TMR_W'(CW_TICKS - 1);
	localparam logic [TMR_W-1:0] OW_LAST = TMR_W'(OW_TICKS - 1);
	localparam logic [TMR_W-1:0] WDR_LAST = TMR_W'(WDR_TICKS - 1);
	localparam logic [TMR_W-1:0] POR_LAST = SLEEP_VARIANT ?
		TMR_W'(POR_TICKS - 1) : TMR_W'(POR_QTR_TICKS - 1);
	localparam logic [TMR_W-1:0] SLP_LO_LAST = TMR_W'(SLEEP_PULSE_TICKS - 1);
	localparam logic [TMR_W-1:0] SLP_HI_LAST = TMR_W'(SLEEP_PERIOD_TICKS - SLEEP_PULSE_TICKS - 1);
	localparam logic [1:0] SVC_DONE = 2'(`WWD_SERVICES_FOR_EN);
	localparam logic [1:0] MISS_DONE = 2'(`WWD_MISSES_FOR_SLEEP);

	wwd_tick_if tb ();

	wwd_pkg::wwd_state_t state_reg;
	logic [TMR_W-1:0] timer_reg;
	logic restart_reg;
	logic trig_meta_reg;
	logic trig_sync_reg;
	logic trig_prev_reg;
	logic trig_fall;
	logic trig_rise;
	logic [15:0] vin_cnt_reg;
	logic lowv_reg;
	logic [1:0] svc_cnt_reg;
	logic [1:0] miss_cnt_reg;
	logic reset_out_n_reg;
	logic enable_n_reg;
	logic sleep_reg;
	logic reset_active;
	logic tick_end;

	wwd_tick #(
		.NORM_CYC(NORM_TICK_CYC),
		.SLOW_CYC(SLOW_TICK_CYC),
		.PRE_W(20)
	) u_tick (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tb(tb)
	);

	assign tb.restart = restart_reg;
	// The sleep states run from the slow time base.
	assign tb.slow = (state_reg == wwd_pkg::WWD_ST_SLEEP_HI) ||
		(state_reg == wwd_pkg::WWD_ST_SLEEP_LO);

	// Two-stage synchroniser, then edge detection on the second stage only.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			trig_meta_reg <= 1'b1;
			trig_sync_reg <= 1'b1;
			trig_prev_reg <= 1'b1;
		end else begin
			trig_meta_reg <= watchdog_trigger_n_i;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
		end
	end

	assign trig_fall = trig_prev_reg && !trig_sync_reg;
	assign trig_rise = !trig_prev_reg && trig_sync_reg;

	// A low level must persist for the reaction time before it counts.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			vin_cnt_reg <= '0;
			lowv_reg <= 1'b0;
		end else if (!monitored_voltage_low_i) begin
			vin_cnt_reg <= '0;
			lowv_reg <= 1'b0;
		end else if (vin_cnt_reg >= 16'(VIN_REACT_CYC - 1)) begin
			lowv_reg <= 1'b1;
		end else begin
			vin_cnt_reg <= vin_cnt_reg + 1'b1;
		end
	end

	// Current interval ends on the tick that completes its last count.
	always_comb begin
		tick_end = 1'b0;
		if (tb.tick) begin
			case (state_reg)
				wwd_pkg::WWD_ST_POR: tick_end = (timer_reg == POR_LAST);
				wwd_pkg::WWD_ST_CLOSED: tick_end = (timer_reg == CW_LAST);
				wwd_pkg::WWD_ST_OPEN: tick_end = (timer_reg == OW_LAST);
				wwd_pkg::WWD_ST_WDR: tick_end = (timer_reg == WDR_LAST);
				wwd_pkg::WWD_ST_SLEEP_HI: tick_end = (timer_reg == SLP_HI_LAST);
				wwd_pkg::WWD_ST_SLEEP_LO: tick_end = (timer_reg == SLP_LO_LAST);
				default: tick_end = 1'b0;
			endcase
		end
	end

	// Sequencer and interval timer.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg <= wwd_pkg::WWD_ST_POR;
			timer_reg <= '0;
			restart_reg <= 1'b1;
		end else if (lowv_reg) begin
			// Low voltage overrides everything and rearms the power-on delay.
			state_reg <= wwd_pkg::WWD_ST_POR;
			timer_reg <= '0;
			restart_reg <= 1'b1;
		end else begin
			restart_reg <= 1'b0;
			case (state_reg)
				wwd_pkg::WWD_ST_POR: begin
					// Trigger edges are not looked at while the delay runs.
					if (tick_end) begin
						state_reg <= wwd_pkg::WWD_ST_CLOSED;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tb.tick) begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				wwd_pkg::WWD_ST_CLOSED: begin
					if (trig_fall) begin
						state_reg <= wwd_pkg::WWD_ST_WDR;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tick_end) begin
						state_reg <= wwd_pkg::WWD_ST_OPEN;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tb.tick) begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				wwd_pkg::WWD_ST_OPEN: begin
					if (trig_fall) begin
						// Service clears the timer and restarts closed.
						state_reg <= wwd_pkg::WWD_ST_CLOSED;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tick_end) begin
						state_reg <= wwd_pkg::WWD_ST_WDR;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tb.tick) begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				wwd_pkg::WWD_ST_WDR: begin
					if (tick_end) begin
						timer_reg <= '0;
						restart_reg <= 1'b1;
						// Pulses repeat through a new closed window; after the third miss the sleep variant enters sleep instead.
						if (SLEEP_VARIANT && miss_cnt_reg == MISS_DONE) begin
							state_reg <= wwd_pkg::WWD_ST_SLEEP_HI;
						end else begin
							state_reg <= wwd_pkg::WWD_ST_CLOSED;
						end
					end else if (tb.tick) begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				wwd_pkg::WWD_ST_SLEEP_HI,
				wwd_pkg::WWD_ST_SLEEP_LO: begin
					if (trig_fall || trig_rise) begin
						state_reg <= wwd_pkg::WWD_ST_CLOSED;
						timer_reg <= '0;
						restart_reg <= 1'b1;
					end else if (tick_end) begin
						timer_reg <= '0;
						restart_reg <= 1'b1;
						if (state_reg == wwd_pkg::WWD_ST_SLEEP_HI) begin
							state_reg <= wwd_pkg::WWD_ST_SLEEP_LO;
						end else begin
							state_reg <= wwd_pkg::WWD_ST_SLEEP_HI;
						end
					end else if (tb.tick) begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				default: begin
					state_reg <= wwd_pkg::WWD_ST_POR;
					timer_reg <= '0;
					restart_reg <= 1'b1;
				end
			endcase
		end
	end

	// Counts consecutive good services and consecutive missed windows.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || lowv_reg) begin
			svc_cnt_reg <= '0;
			miss_cnt_reg <= '0;
		end else begin
			case (state_reg)
				wwd_pkg::WWD_ST_CLOSED: begin
					if (trig_fall) begin
						svc_cnt_reg <= '0;
						miss_cnt_reg <= '0;
					end
				end
				wwd_pkg::WWD_ST_OPEN: begin
					if (trig_fall) begin
						miss_cnt_reg <= '0;
						if (svc_cnt_reg != SVC_DONE) begin
							svc_cnt_reg <= svc_cnt_reg + 1'b1;
						end
					end else if (tick_end) begin
						svc_cnt_reg <= '0;
						if (miss_cnt_reg != MISS_DONE) begin
							miss_cnt_reg <= miss_cnt_reg + 1'b1;
						end
					end
				end
				wwd_pkg::WWD_ST_SLEEP_HI,
				wwd_pkg::WWD_ST_SLEEP_LO: begin
					svc_cnt_reg <= '0;
					if (trig_fall || trig_rise) begin
						miss_cnt_reg <= '0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (state_reg)
			wwd_pkg::WWD_ST_POR: reset_active = 1'b1;
			wwd_pkg::WWD_ST_WDR: reset_active = 1'b1;
			wwd_pkg::WWD_ST_SLEEP_LO: reset_active = 1'b1;
			default: reset_active = lowv_reg;
		endcase
	end

	// Pin drivers; the reset pin is open drain, enabled low while pulling low.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			reset_out_n_reg <= 1'b0;
			enable_n_reg <= 1'b1;
			sleep_reg <= 1'b0;
		end else begin
			reset_out_n_reg <= !reset_active;
			sleep_reg <= tb.slow;
			if (reset_active) begin
				enable_n_reg <= 1'b1;
			end else if (svc_cnt_reg == SVC_DONE) begin
				enable_n_reg <= 1'b0;
			end else begin
				enable_n_reg <= 1'b1;
			end
		end
	end

	assign reset_out_n_o = reset_out_n_reg;
	assign reset_out_oe_b_o = reset_out_n_reg;
	assign enable_n_o = enable_n_reg;
	assign sleep_o = sleep_reg;
endmodule
